// File: core/cs_space_wait_idle_control.sv
// Chip-select space timing control: registers, access sequencer and wait handling.
`timescale 1ns/10ps
module cs_space_wait_idle_control (
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic [cs_ctrl_pkg::ADDR_W-1:0] address,
    input  wire logic [cs_ctrl_pkg::DATA_W-1:0] write_data,
    input  wire logic [cs_ctrl_pkg::LANES-1:0]  write_lanes,
    input  wire logic                           write_strobe,
    input  wire logic                           read_strobe,
    output logic      [cs_ctrl_pkg::DATA_W-1:0] read_data,
    input  wire logic                           access_request,
    input  wire logic [1:0]                     access_space,
    input  wire logic                           access_write,
    output logic                                access_busy,
    output logic                                access_done,
    output logic      [cs_ctrl_pkg::CS_COUNT-1:0] select_n,
    output logic                                read_n,
    output logic                                write_n,
    output logic                                bus_width_16,
    input  wire logic                           wait_n,
    input  wire logic                           rom_enabled,
    input  wire logic                           mode_bus_width_16
);
    import cs_ctrl_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]      idle_ctrl;
        logic [DATA_W-1:0]      wait_ctrl;
        logic [CS_COUNT-1:0]    size_bits;
        logic [DATA_W-1:0]      rdata;
        phase_t                 phase;
        logic [1:0]             cs;
        logic                   wr;
        logic [POST_IDLE_W-1:0] gap;
        logic                   pend;
        logic                   follow;
        logic [1:0]             last_cs;
        logic [CS_COUNT-1:0]    select_n;
        logic                   read_n;
        logic                   write_n;
        logic                   done;
        logic                   busy;
        logic                   width16;
        logic                   wait_s1;
        logic                   wait_s2;
        logic                   wait_s3;
        logic                   wait_level;
        logic                   strap_taken;
        logic                   rom_on;
        logic                   mode_w16;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    wait_timing_if tif ();

    // Merges write data into a register under the byte-lane enables.
    function automatic logic [DATA_W-1:0] merge_lanes(
        input logic [DATA_W-1:0] old_value,
        input logic [DATA_W-1:0] data,
        input logic [LANES-1:0]  lanes
    );
        logic [DATA_W-1:0] result;
        result = old_value;
        if (lanes[0])
        begin
            result[7:0] = data[7:0];
        end
        if (lanes[1])
        begin
            result[15:8] = data[15:8];
        end
        return result;
    endfunction

    // Post-access idle count of one space.
    function automatic logic [POST_IDLE_W-1:0] post_idle_of(
        input logic [DATA_W-1:0] idle_reg,
        input logic [1:0]        cs
    );
        return idle_reg[POST_IDLE_LSB + POST_IDLE_W * int'(cs) +: POST_IDLE_W];
    endfunction

    // Wait count of one space.
    function automatic logic [WAIT_W-1:0] wait_of(
        input logic [DATA_W-1:0] wait_reg,
        input logic [1:0]        cs
    );
        return wait_reg[WAIT_W * int'(cs) +: WAIT_W];
    endfunction

    // Effective bus width of one space.
    function automatic logic width_of(
        input logic [CS_COUNT-1:0] size_bits,
        input logic                rom_on,
        input logic                mode_w16,
        input logic [1:0]          cs
    );
        logic result;
        result = size_bits[cs];
        if (cs == 2'h0)
        begin
            result = rom_on ? size_bits[0] : mode_w16;
        end
        return result;
    endfunction

    // The timer loads as the setup cycle hands over to the strobe phase.
    assign tif.start      = (s.phase == PH_SETUP);
    assign tif.count      = wait_of(s.wait_ctrl, s.cs);
    assign tif.wait_level = s.wait_level;

    wait_state_timer timer (
        .clk   (clk),
        .reset (reset),
        .t     (tif)
    );

    // Next-state logic for registers, synchroniser, straps and the access sequencer.
    always_comb
    begin
        next_s      = s;
        next_s.done = 1'b0;

        // Wait pin passes three stages; a change counts once the last two agree.
        next_s.wait_s1 = ~wait_n;
        next_s.wait_s2 = s.wait_s1;
        next_s.wait_s3 = s.wait_s2;
        if (s.wait_s2 == s.wait_s3)
        begin
            next_s.wait_level = s.wait_s3;
        end

        // Straps are caught once, in the first cycle after reset is released.
        if (!s.strap_taken)
        begin
            next_s.strap_taken = 1'b1;
            next_s.rom_on      = rom_enabled;
            next_s.mode_w16    = mode_bus_width_16;
        end

        // Register writes; only the addressed register and enabled lanes change.
        if (write_strobe)
        begin
            case (address)
                SIZE_OFFSET:
                begin
                    if (write_lanes[0])
                    begin
                        next_s.size_bits = write_data[SIZE_LSB +: CS_COUNT];
                    end
                end
                IDLE_OFFSET:
                begin
                    next_s.idle_ctrl = merge_lanes(s.idle_ctrl, write_data, write_lanes);
                end
                WAIT_OFFSET:
                begin
                    next_s.wait_ctrl = merge_lanes(s.wait_ctrl, write_data, write_lanes);
                end
                default:
                begin
                    next_s.size_bits = s.size_bits;
                end
            endcase
        end

        // Read data stand only in the cycle after the strobe; unmapped reads give zero.
        next_s.rdata = '0;
        if (read_strobe)
        begin
            case (address)
                SIZE_OFFSET:
                begin
                    next_s.rdata = {12'h000, s.size_bits};
                end
                IDLE_OFFSET:
                begin
                    next_s.rdata = s.idle_ctrl;
                end
                WAIT_OFFSET:
                begin
                    next_s.rdata = s.wait_ctrl;
                end
                default:
                begin
                    next_s.rdata = '0;
                end
            endcase
        end

        // Access sequencer.
        case (s.phase)
            PH_IDLE:
            begin
                next_s.follow = 1'b0;
                if (access_request)
                begin
                    next_s.cs      = access_space;
                    next_s.wr      = access_write;
                    next_s.width16 = width_of(s.size_bits, s.rom_on, s.mode_w16,
                                              access_space);
                    if (s.follow && (access_space == s.last_cs)
                        && s.idle_ctrl[BTB_LSB + int'(access_space)])
                    begin
                        next_s.phase = PH_GAP;
                        next_s.gap   = BTB_GAP;
                        next_s.pend  = 1'b1;
                    end
                    else
                    begin
                        next_s.phase = PH_SETUP;
                    end
                end
            end
            PH_SETUP:
            begin
                next_s.phase = PH_STROBE;
            end
            PH_STROBE:
            begin
                if (tif.expired)
                begin
                    next_s.done    = 1'b1;
                    next_s.last_cs = s.cs;
                    if (s.idle_ctrl[STRETCH_LSB + int'(s.cs)])
                    begin
                        next_s.phase = PH_STRETCH;
                    end
                    else
                    begin
                        next_s.gap = post_idle_of(s.idle_ctrl, s.cs);
                        if (post_idle_of(s.idle_ctrl, s.cs) != '0)
                        begin
                            next_s.phase = PH_GAP;
                        end
                        else
                        begin
                            next_s.phase  = PH_IDLE;
                            next_s.follow = 1'b1;
                        end
                    end
                end
            end
            PH_STRETCH:
            begin
                next_s.gap = post_idle_of(s.idle_ctrl, s.cs);
                if (post_idle_of(s.idle_ctrl, s.cs) != '0)
                begin
                    next_s.phase = PH_GAP;
                end
                else
                begin
                    next_s.phase  = PH_IDLE;
                    next_s.follow = 1'b1;
                end
            end
            PH_GAP:
            begin
                if (s.gap > 2'h1)
                begin
                    next_s.gap = s.gap - 2'h1;
                end
                else if (s.pend)
                begin
                    next_s.pend  = 1'b0;
                    next_s.phase = PH_SETUP;
                end
                else
                begin
                    next_s.phase = PH_IDLE;
                end
            end
            default:
            begin
                next_s.phase = PH_IDLE;
            end
        endcase

        // Pin levels follow the phase being entered, so they leave a flip-flop.
        next_s.select_n = '1;
        if ((next_s.phase == PH_SETUP) || (next_s.phase == PH_STROBE)
            || (next_s.phase == PH_STRETCH))
        begin
            next_s.select_n[next_s.cs] = 1'b0;
        end
        next_s.read_n  = !((next_s.phase == PH_STROBE) && !next_s.wr);
        next_s.write_n = !((next_s.phase == PH_STROBE) && next_s.wr);
        next_s.busy    = (next_s.phase != PH_IDLE);
    end

    // State register with synchronous reset.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s <= '0;
            s.idle_ctrl <= IDLE_RESET;
            s.wait_ctrl <= WAIT_RESET;
            s.size_bits <= SIZE_RESET;
            s.phase     <= PH_IDLE;
            s.select_n  <= '1;
            s.read_n    <= 1'b1;
            s.write_n   <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state register.
    assign read_data    = s.rdata;
    assign access_busy  = s.busy;
    assign access_done  = s.done;
    assign select_n     = s.select_n;
    assign read_n       = s.read_n;
    assign write_n      = s.write_n;
    assign bus_width_16 = s.width16;

endmodule

// File: shared/cs_ctrl_pkg.sv
// Shared constants, field layout and types for the chip-select space timing control.
package cs_ctrl_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam int LANES  = 2;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] SIZE_OFFSET = 32'hFFFF8620;
    localparam logic [ADDR_W-1:0] IDLE_OFFSET = 32'hFFFF8622;
    localparam logic [ADDR_W-1:0] WAIT_OFFSET = 32'hFFFF8624;

    // Reset values.
    localparam logic [DATA_W-1:0] IDLE_RESET = 16'hFFFF;
    localparam logic [DATA_W-1:0] WAIT_RESET = 16'hFFFF;
    localparam logic [3:0]        SIZE_RESET = 4'hF;

    // Field positions and widths.
    localparam int CS_COUNT      = 4;
    localparam int POST_IDLE_LSB = 8;
    localparam int POST_IDLE_W   = 2;
    localparam int BTB_LSB       = 4;
    localparam int STRETCH_LSB   = 0;
    localparam int WAIT_W        = 4;
    localparam int SIZE_LSB      = 0;

    // Idle cycles inserted between consecutive accesses to one space.
    localparam logic [POST_IDLE_W-1:0] BTB_GAP = 2'h1;

    // Phases of one external access.
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_SETUP,
        PH_STROBE,
        PH_STRETCH,
        PH_GAP
    } phase_t;

endpackage

// File: shared/wait_timing_if.sv
// Handshake between the access sequencer and the wait-state timer.
`timescale 1ns/10ps
interface wait_timing_if;
    logic                         start;
    logic [cs_ctrl_pkg::WAIT_W-1:0] count;
    logic                         wait_level;
    logic                         expired;

    modport control (output start, output count, output wait_level, input expired);
    modport timer   (input start, input count, input wait_level, output expired);
endinterface

// File: core/wait_state_timer.sv
// Wait-state counter with optional external wait input extension.
`timescale 1ns/10ps
module wait_state_timer (
    input wire logic clk,
    input wire logic reset,
    wait_timing_if.timer t
);
    import cs_ctrl_pkg::*;

    typedef struct packed {
        logic              running;
        logic [WAIT_W-1:0] remain;
        logic              sample;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;

    // Load on start, count the wait states down, then hold while wait is asserted if the loaded count was not zero.
    always_comb
    begin
        next_s = s;
        if (t.start)
        begin
            next_s.running = 1'b1;
            next_s.remain  = t.count;
            next_s.sample  = (t.count != '0);
        end
        else if (s.running)
        begin
            if (s.remain != '0)
            begin
                next_s.remain = s.remain - 4'h1;
            end
            else if (!(s.sample && t.wait_level))
            begin
                next_s.running = 1'b0;
            end
        end
    end

    // The strobe phase may end in the cycle the count is used up and wait is clear.
    // count then sample
    assign t.expired = s.running && (s.remain == '0) && !(s.sample && t.wait_level);

    // State register.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

// File: sim/cs_space_wait_idle_control_assertions.sv
// Concurrent checks on the ports of the chip-select timing controller.
`timescale 1ns/10ps
module cs_space_wait_idle_control_assertions (
    input wire logic                             clk,
    input wire logic                             reset,
    input wire logic                             read_strobe,
    input wire logic [cs_ctrl_pkg::DATA_W-1:0]   read_data,
    input wire logic                             access_request,
    input wire logic [1:0]                       access_space,
    input wire logic                             access_write,
    input wire logic                             access_busy,
    input wire logic                             access_done,
    input wire logic [cs_ctrl_pkg::CS_COUNT-1:0] select_n,
    input wire logic                             read_n,
    input wire logic                             write_n,
    input wire logic                             bus_width_16,
    input wire logic                             rom_enabled,
    input wire logic                             mode_bus_width_16
);
    import cs_ctrl_pkg::*;
    wire take = access_request && !access_busy;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_done_pulse: assert property (access_done |=> !access_done)
        else $error("done pulse longer than one cycle");
    a_sel_onehot: assert property (select_n != 4'hF |-> $onehot(~select_n) && access_busy)
        else $error("bad chip select pattern");
    a_strobe_sel:
        assert property (!(read_n && write_n) |-> select_n != 4'hF && (read_n || write_n))
        else $error("strobe outside a selected access");
    // A follow-on access to the same space may open with one idle cycle before its setup.
    a_take_sel:
        assert property (take |=> (select_n == ~(4'h1 << $past(access_space)) && read_n)
            or (select_n == 4'hF && access_busy
            ##1 select_n == ~(4'h1 << $past(access_space, 2)) && read_n))
        else $error("setup cycle does not select the requested space");
    a_take_dir:
        assert property (take |=> (select_n != 4'hF
            ##1 write_n != $past(access_write, 2) && read_n == $past(access_write, 2))
            or (select_n == 4'hF
            ##2 write_n != $past(access_write, 3) && read_n == $past(access_write, 3)))
        else $error("strobe does not follow the setup cycle");
    a_done_end: assert property (access_done |-> read_n && write_n && $past(!(read_n && write_n)))
        else $error("done not at end of strobe");
    a_rd_quiet:
        assert property (read_data != 16'h0 |-> $past(read_strobe))
        else $error("read data outside its cycle");
    a_cs0_mode:
        assert property (take && access_space == 2'h0 && !rom_enabled
            |=> bus_width_16 == mode_bus_width_16)
        else $error("cs0 width not from mode pin");

    c_write: cover property (take && access_write);
    c_cs0_mode: cover property (take && access_space == 2'h0 && !rom_enabled);
    c_gap: cover property (access_busy && select_n == 4'hF ##1 select_n != 4'hF);
endmodule

bind cs_space_wait_idle_control cs_space_wait_idle_control_assertions chk (
    .clk, .reset, .read_strobe, .read_data, .access_request, .access_space, .access_write,
    .access_busy, .access_done, .select_n, .read_n, .write_n, .bus_width_16, .rom_enabled,
    .mode_bus_width_16);

// File: sim/cs_wait_device.sv
// Behavioural external device that stretches accesses through its wait output.
`timescale 1ns/10ps
module cs_wait_device (
    input wire logic       clk,
    input wire logic [3:0] select_n,
    input wire logic [7:0] hold,
    output logic           wait_n
);
    logic [7:0] left;

    // hold wait asserted
    // Counts down the time the device still needs once it is selected.
    always_ff @(posedge clk)
    begin
        if (select_n == 4'hF)
            left <= hold;
        else if (left != 8'h0)
            left <= left - 8'h1;
    end

    // The wait line is pulled up whenever the device is idle or ready.
    assign wait_n = !(select_n != 4'hF && left != 8'h0);
endmodule

// File: sim/cs_space_wait_idle_control_tb.sv
// Self-checking bench for the chip-select timing controller.
`timescale 1ns/10ps
module cs_space_wait_idle_control_tb;
    import cs_ctrl_pkg::*;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] write_data, read_data;
    logic [1:0]        write_lanes, access_space;
    logic [3:0]        select_n;
    logic [7:0]        hold;
    logic              clk, reset, write_strobe, read_strobe, access_request, access_write;
    logic              access_busy, access_done, read_n, write_n, bus_width_16, wait_n;
    logic              rom_enabled, mode_bus_width_16;
    int                mismatches, n_compared, lead, strb, sel, gap, n, p, st;
    int                cycles = 0;

    // Free-running system clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    cs_space_wait_idle_control uut (.clk, .reset, .address, .write_data, .write_lanes,
        .write_strobe, .read_strobe, .read_data, .access_request, .access_space, .access_write,
        .access_busy, .access_done, .select_n, .read_n, .write_n, .bus_width_16, .wait_n,
        .rom_enabled, .mode_bus_width_16);
    cs_wait_device dev (.clk, .select_n, .hold, .wait_n);

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [1:0] l);
        @(posedge clk);
        address <= a;
        write_data <= d;
        write_lanes <= l;
        write_strobe <= 1'b1;
        @(posedge clk);
        write_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge clk);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clk);
        read_strobe <= 1'b0;
        @(negedge clk);
        chk(read_data, exp);
    endtask

    // Runs one access and counts lead idle, strobe, select and gap cycles.
    task automatic acc(input logic [1:0] s, input logic w, input logic keep);
        logic seen_sel;
        logic up;
        int k;
        lead = 0;
        strb = 0;
        sel = 0;
        gap = 0;
        k = 0;
        seen_sel = 1'b0;
        @(posedge clk);
        access_request <= 1'b1;
        access_space <= s;
        access_write <= w;
        @(negedge clk);
        while (k < 100 && !(seen_sel && access_busy === 1'b0))
        begin
            if (select_n !== 4'hF)
            begin
                sel++;
                seen_sel = 1'b1;
            end
            else if (access_busy === 1'b1)
            begin
                if (seen_sel)
                    gap++;
                else
                    lead++;
            end
            if (!(read_n && write_n))
                strb++;
            up = access_busy;
            @(posedge clk);
            if (up && !keep)
                access_request <= 1'b0;
            @(negedge clk);
            k++;
        end
        // An access that never ends is a failure of its own.
        if (k >= 100)
        begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic do_reset(input logic rom, input logic mode);
        @(posedge clk);
        reset <= 1'b1;
        rom_enabled <= rom;
        mode_bus_width_16 <= mode;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
    endtask

    // Main sequence.
    initial
    begin
        reset = 1'b1;
        address = '0;
        write_data = '0;
        write_lanes = 2'h0;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        access_request = 1'b0;
        access_space = 2'h0;
        access_write = 1'b0;
        rom_enabled = 1'b1;
        mode_bus_width_16 = 1'b0;
        hold = 8'h0;
        mismatches = 0;
        n_compared = 0;
        do_reset(1'b1, 1'b0);
        rd(IDLE_OFFSET, 16'hFFFF);
        rd(WAIT_OFFSET, 16'hFFFF);
        rd(SIZE_OFFSET, 16'h000F);
        rd(32'hFFFF8628, 16'h0000);
        acc(2'h1, 1'b0, 1'b0);
        chk(16'(strb), 16'h0010);
        chk(16'(sel), 16'h0012);
        chk(16'(gap), 16'h0003);
        wr(IDLE_OFFSET, 16'h1234, 2'h1);
        rd(IDLE_OFFSET, 16'hFF34);
        wr(IDLE_OFFSET, 16'hC41A, 2'h3);
        wr(WAIT_OFFSET, 16'h3021, 2'h3);
        wr(32'hFFFF8628, 16'h0000, 2'h3);
        wr(SIZE_OFFSET, 16'h0005, 2'h1);
        rd(IDLE_OFFSET, 16'hC41A);
        rd(WAIT_OFFSET, 16'h3021);
        for (int s = 0; s < 4; s++)
        begin
            n = (16'h3021 >> (4 * s)) & 15;
            p = (16'hC41A >> (8 + 2 * s)) & 3;
            st = (16'hC41A >> s) & 1;
            acc(2'(s), s[0], 1'b0);
            chk(16'(strb), 16'(n + 1));
            chk(16'(sel), 16'(n + 2 + st));
            chk(16'(gap), 16'(p));
            chk(16'(bus_width_16), 16'((4'h5 >> s) & 1));
        end
        hold = 8'd20;
        acc(2'h3, 1'b1, 1'b0);
        chk(16'(strb > 4), 16'h0001);
        acc(2'h2, 1'b0, 1'b0);
        chk(16'(strb), 16'h0001);
        hold = 8'h0;
        // A request left standing is taken with the qualifiers it already carries.
        acc(2'h0, 1'b0, 1'b1);
        acc(2'h0, 1'b0, 1'b0);
        chk(16'(lead), 16'h0001);
        chk(16'(strb), 16'h0002);
        acc(2'h2, 1'b0, 1'b1);
        acc(2'h2, 1'b0, 1'b0);
        chk(16'(lead), 16'h0000);
        do_reset(1'b0, 1'b0);
        acc(2'h0, 1'b0, 1'b0);
        chk(16'(bus_width_16), 16'h0000);
        acc(2'h1, 1'b0, 1'b0);
        chk(16'(bus_width_16), 16'h0001);
        // Wide mode strap with the stored CS0 bit cleared, which must have no effect.
        do_reset(1'b0, 1'b1);
        wr(SIZE_OFFSET, 16'h000E, 2'h1);
        acc(2'h0, 1'b0, 1'b0);
        chk(16'(bus_width_16), 16'h0001);
        conclude();
    end
endmodule
